// [include/sirp_regs.svh]
`ifndef SIRP_REGS_SVH
`define SIRP_REGS_SVH
// identity word field positions
`define SIRP_MAKER_MSB 31
`define SIRP_MAKER_LSB 21
`define SIRP_PART_MSB 20
`define SIRP_PART_LSB 7
`define SIRP_CAP_MSB 6
`define SIRP_CAP_LSB 3
`define SIRP_REV_MSB 2
`define SIRP_REV_LSB 0
// default field values, arbitrary
`define SIRP_MAKER_DEF 11'h155
`define SIRP_PART_DEF 14'h0a5a
`define SIRP_CAP_DEF 4'h3
`define SIRP_REV_DEF 3'h2
// default opcodes, arbitrary
`define SIRP_OP_IDENT 8'h9f
`define SIRP_OP_FAST_IDENT 8'h99
// link clock limits in MHz
`define SIRP_NORMAL_MAX_MHZ 40
`define SIRP_FAST_MAX_MHZ 104
// link clock divider (half period in ref_clk cycles), 80 ns half period
`define SIRP_HALF_NS 80
`define SIRP_CLK_NS 10
`define SIRP_HALF_CYC (`SIRP_HALF_NS / `SIRP_CLK_NS)
`endif

// [include/sirp_pkg.sv]
package sirp_pkg;
   typedef enum logic [2:0] {
      SIRP_IDLE = 3'h0,
      SIRP_OPC = 3'h1,
      SIRP_DUMMY = 3'h3,
      SIRP_DATA = 3'h2,
      SIRP_DONE = 3'h6
   } sirp_state_e;
   typedef logic [31:0] sirp_word_t;
endpackage

// [include/sirp_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface sirp_if;
   logic selN;
   logic sclk;
   logic sdi;
   logic pauseN;
   logic sdo;
   logic sdoEn;
   modport device (input selN, input sclk, input sdi, input pauseN, output sdo, output sdoEn);
   modport master (output selN, output sclk, output sdi, output pauseN, input sdo, input sdoEn);
endinterface
`default_nettype wire

// [hdl/sirp_device.sv]
// Operation
// [RULE1] part code is fourteen bits wide
// [RULE2] capacity code is four bits wide
// [RULE3] revision field three bits, fixed value
// [RULE4] normal read for link clock to 40 MHz
// [RULE5] normal opcode then four identity bytes out
// [RULE6] fast opcode, dummy byte, then four bytes
// [RULE7] fast read above 40 up to 104 MHz
// [RULE8] pause suspends transfer, keeps sequence state
// [RULE9] master lowers pause only while clock low
// [RULE10] master raises pause only while clock low
// [RULE11] clock edges during pause are ignored
// [RULE12] paused: input ignored, output high impedance
// [RULE13] paused sequence survives deselection
// [RULE14] reselect and release pause to continue
// [RULE15] identity word is read only
// [RULE16] field layout 31-21, 20-7, 6-3, 2-0
// [RULE17] maker code: three bank, eight code bits
// [RULE18] msb byte and bit first, mode 0/3
// [RULE19] opcodes are configurable constants
`timescale 1ns/1ps
`default_nettype none
`include "sirp_regs.svh"
module sirp_device
   import sirp_pkg::*;
#(
   parameter logic [2:0] MAKER_BANK = 3'(`SIRP_MAKER_DEF >> 8),
   parameter logic [7:0] MAKER_CODE = 8'(`SIRP_MAKER_DEF),
   parameter logic [13:0] PART_CODE = `SIRP_PART_DEF,
   parameter logic [3:0] CAP_CODE = `SIRP_CAP_DEF,
   parameter logic [2:0] REV_CODE = `SIRP_REV_DEF,
   parameter logic [7:0] OP_IDENT = `SIRP_OP_IDENT,
   parameter logic [7:0] OP_FAST_IDENT = `SIRP_OP_FAST_IDENT
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // link
   sirp_if.device link,
   // user side status
   output logic busy,
   output logic paused
);
   // ***************************************************************
   // identity word
   // ***************************************************************
   sirp_word_t identityWord;
   // constant only; no path writes it [RULE15]
   always_comb begin
      identityWord = '0;
      identityWord[`SIRP_MAKER_MSB:`SIRP_MAKER_LSB] = {MAKER_BANK, MAKER_CODE}; // [RULE17] [RULE16]
      identityWord[`SIRP_PART_MSB:`SIRP_PART_LSB] = PART_CODE; // [RULE1]
      identityWord[`SIRP_CAP_MSB:`SIRP_CAP_LSB] = CAP_CODE; // [RULE2]
      identityWord[`SIRP_REV_MSB:`SIRP_REV_LSB] = REV_CODE; // [RULE3]
   end

   // ***************************************************************
   // pin synchronisers
   // ***************************************************************
   logic [3:0] syncA_q;
   logic [3:0] syncB_q;
   logic sclkOld_q;
   // two flops per pin before any logic looks at them
   // reset to the idle pin levels so no false clock edge follows reset
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         syncA_q <= 4'h9;
         syncB_q <= 4'h9;
         sclkOld_q <= 1'b0;
      end else begin
         syncA_q <= {link.selN, link.sclk, link.sdi, link.pauseN};
         syncB_q <= syncA_q;
         sclkOld_q <= syncB_q[2];
      end
   end
   logic selN, sclkS, sdiS, pauseNS, rise, fall;
   assign selN = syncB_q[3];
   assign sclkS = syncB_q[2];
   assign sdiS = syncB_q[1];
   assign pauseNS = syncB_q[0];
   assign rise = sclkS & ~sclkOld_q;
   assign fall = ~sclkS & sclkOld_q;

   // ***************************************************************
   // pause latch
   // ***************************************************************
   logic hold_q;
   logic selected;
   // pause takes effect while selected; release needs selection too [RULE14]
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         hold_q <= 1'b0;
      end else if (!selN) begin
         hold_q <= ~pauseNS; // [RULE8]
      end
   end
   // a held sequence outlives chip select going high [RULE13]
   assign selected = ~selN & ~hold_q & pauseNS;

   // ***************************************************************
   // command sequencer
   // ***************************************************************
   sirp_state_e state_q;
   logic [7:0] shiftIn_q;
   logic [2:0] bitCnt_q;
   logic [1:0] byteCnt_q;
   logic [31:0] shiftOut_q;
   logic outOn_q;
   logic lastByte;
   assign lastByte = bitCnt_q == 3'h7;
   // clock edges only count while selected and not held [RULE11]
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_q <= SIRP_IDLE;
         shiftIn_q <= 8'h00;
         bitCnt_q <= 3'h0;
         byteCnt_q <= 2'h0;
      end else if (selN && !hold_q) begin
         state_q <= SIRP_IDLE; // plain deselect ends the command
         bitCnt_q <= 3'h0;
         byteCnt_q <= 2'h0;
      end else if (selected && rise) begin
         shiftIn_q <= {shiftIn_q[6:0], sdiS}; // input sampled only unpaused [RULE12]
         bitCnt_q <= bitCnt_q + 3'h1;
         case (state_q)
            SIRP_IDLE, SIRP_OPC: begin
               state_q <= SIRP_OPC;
               if (lastByte) begin
                  // opcodes are parameters [RULE19]
                  if ({shiftIn_q[6:0], sdiS} == OP_IDENT) begin
                     state_q <= SIRP_DATA; // [RULE5] [RULE4]
                  end else if ({shiftIn_q[6:0], sdiS} == OP_FAST_IDENT) begin
                     state_q <= SIRP_DUMMY; // [RULE6] [RULE7]
                  end else begin
                     state_q <= SIRP_DONE;
                  end
               end
            end
            SIRP_DUMMY: begin
               if (lastByte) begin
                  state_q <= SIRP_DATA; // [RULE6]
               end
            end
            SIRP_DATA: begin
               if (lastByte) begin
                  byteCnt_q <= byteCnt_q + 2'h1;
                  if (byteCnt_q == 2'h3) begin
                     state_q <= SIRP_DONE; // four bytes, no wrap [RULE5]
                  end
               end
            end
            SIRP_DONE: state_q <= SIRP_DONE;
            default: state_q <= SIRP_IDLE;
         endcase
      end
   end

   // ***************************************************************
   // output shifter
   // ***************************************************************
   // load on entry, change on falling edge so master samples on rise
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         shiftOut_q <= 32'h0000_0000;
         outOn_q <= 1'b0;
      end else if (selN && !hold_q) begin
         outOn_q <= 1'b0;
      end else if (selected && fall) begin
         if (state_q == SIRP_DATA && !outOn_q) begin
            shiftOut_q <= identityWord; // msb byte, msb bit first [RULE18]
            outOn_q <= 1'b1;
         end else if (state_q == SIRP_DATA) begin
            shiftOut_q <= {shiftOut_q[30:0], 1'b0}; // [RULE18]
         end else begin
            outOn_q <= 1'b0;
         end
      end
   end
   // high impedance while held [RULE12]
   assign link.sdo = shiftOut_q[31];
   assign link.sdoEn = outOn_q & selected;
   assign busy = state_q != SIRP_IDLE;
   assign paused = hold_q;
endmodule // sirp_device
`default_nettype wire

// [hdl/sirp_master.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sirp_regs.svh"
module sirp_master
   import sirp_pkg::*;
#(
   parameter int HALF_CYC = `SIRP_HALF_CYC,
   parameter logic [7:0] OP_IDENT = `SIRP_OP_IDENT,
   parameter logic [7:0] OP_FAST_IDENT = `SIRP_OP_FAST_IDENT
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // link
   sirp_if.master link,
   // user request
   input wire logic start,
   input wire logic fast,
   input wire logic pauseReq,
   output logic ready,
   // user answer
   output logic [31:0] ident,
   output logic done
);
   // ***************************************************************
   // clock divider and bit engine
   // ***************************************************************
   logic [7:0] div_q;
   logic sclk_q, run_q, selN_q, pauseN_q, done_q;
   logic parkSel_q;
   logic [5:0] bits_q, total_q;
   logic [7:0] opc_q;
   logic [31:0] ident_q;
   logic [1:0] sdoA_q, sdoB_q;
   logic tick;
   assign tick = div_q == 8'(HALF_CYC - 1);
   // sdo and its enable pass two flops
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sdoA_q <= 2'h0;
         sdoB_q <= 2'h0;
      end else begin
         sdoA_q <= {link.sdoEn, link.sdo};
         sdoB_q <= sdoA_q;
      end
   end
   // pause edges only while clock low and not about to rise [RULE9] [RULE10]
   // fast reads also let go of select while paused; select comes back
   // one cycle before pause is released, so the device keeps its place
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pauseN_q <= 1'b1;
         parkSel_q <= 1'b0;
      end else begin
         parkSel_q <= run_q & ~pauseN_q & pauseReq & (total_q == 6'd48); // [RULE13]
         if (!sclk_q && !(run_q && tick) && !(parkSel_q && !pauseReq)) begin
            pauseN_q <= ~pauseReq; // [RULE14]
         end
      end
   end
   // mode 0: clock idles low, output on falls, sample on rises
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         div_q <= 8'h00;
         sclk_q <= 1'b0;
         run_q <= 1'b0;
         selN_q <= 1'b1;
         bits_q <= 6'h00;
         total_q <= 6'h00;
         opc_q <= 8'h00;
         ident_q <= 32'h0000_0000;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (!run_q) begin
            if (start) begin
               run_q <= 1'b1;
               selN_q <= 1'b0;
               opc_q <= fast ? OP_FAST_IDENT : OP_IDENT; // [RULE4] [RULE7]
               total_q <= fast ? 6'd48 : 6'd40; // dummy byte for fast [RULE5] [RULE6]
               bits_q <= 6'h00;
               div_q <= 8'h00;
            end
         end else if (!pauseN_q) begin
            div_q <= 8'h00; // clock held low during pause
         end else if (tick) begin
            div_q <= 8'h00;
            sclk_q <= ~sclk_q;
            if (sclk_q) begin
               opc_q <= {opc_q[6:0], 1'b0};
               if (bits_q == total_q) begin
                  run_q <= 1'b0;
                  selN_q <= 1'b1;
                  sclk_q <= 1'b0;
                  done_q <= 1'b1;
               end
            end else begin
               bits_q <= bits_q + 6'h01;
               if (bits_q >= total_q - 6'd32) begin
                  ident_q <= {ident_q[30:0], sdoB_q[0]};
               end
            end
         end else begin
            div_q <= div_q + 8'h01;
         end
      end
   end
   assign link.sclk = sclk_q;
   assign link.selN = selN_q | parkSel_q;
   assign link.sdi = opc_q[7];
   assign link.pauseN = pauseN_q;
   assign ready = ~run_q;
   assign ident = ident_q;
   assign done = done_q;
endmodule // sirp_master
`default_nettype wire

// [sim/sirp_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module sirp_properties (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // link
   input wire logic selN,
   input wire logic sclk,
   input wire logic sdi,
   input wire logic pauseN,
   input wire logic sdo,
   input wire logic sdoEn
);
   // ****************
   // link checks
   // ****************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // resumed frames reopen with pause still low, so they are left out
   sequence frameOpen;
      $fell(selN) && pauseN;
   endsequence
   // four cycles covers the device's pin synchroniser
   sequence heldLong;
      (!pauseN) [*4];
   endsequence
   a_pause_fall_low: assert property ($fell(pauseN) |-> !sclk)
      else $error("pause lowered while link clock high");
   a_pause_rise_low: assert property ($rose(pauseN) |-> !sclk)
      else $error("pause raised while link clock high");
   a_paused_sdo_off: assert property (heldLong |-> !sdoEn)
      else $error("device drives output while paused");
   a_open_clk_low: assert property (frameOpen |-> !sclk)
      else $error("frame opened with link clock high");
   a_opcode_sdo_off: assert property (frameOpen |-> (!sdoEn) throughout (##120 1'b1))
      else $error("device drives output during opcode");
   a_sdo_move_low: assert property (sdoEn && $past(sdoEn) && $changed(sdo) |-> !sclk)
      else $error("output bit changed with link clock high");
   a_sdo_hold_high: assert property (sdoEn && sclk && $past(sclk) |-> $stable(sdo))
      else $error("output bit unstable while link clock high");
   a_sdi_hold_high: assert property (!selN && sclk && $past(sclk) |-> $stable(sdi))
      else $error("input bit unstable while link clock high");
   a_idle_sdo_off: assert property (selN [*4] |-> !sdoEn)
      else $error("device drives output while deselected");
endmodule // sirp_properties
`default_nettype wire

// [sim/tb_sirp.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sirp_regs.svh"
module tb_sirp;
   import sirp_pkg::*;
   // ****************
   // bench
   // ****************
   localparam sirp_word_t EXP_WORD = {3'h5, 8'h3c, 14'h1234, 4'h9, 3'h6};
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic start = 1'b0;
   logic fast = 1'b0;
   logic pauseReq = 1'b0;
   logic ready, done, busy, paused, sclkQ;
   logic [31:0] ident;
   logic [31:0] wireWord;
   int edgeCnt, wireBits;
   int fails = 0;
   int total_checks = 0;
   int pauseTab [5] = '{0, 0, 60, 200, 400};
   sirp_if sirp_if_i ();
   sirp_device #(.MAKER_BANK(3'h5), .MAKER_CODE(8'h3c), .PART_CODE(14'h1234),
      .CAP_CODE(4'h9), .REV_CODE(3'h6)) sirp_device_i (.ref_clk(ref_clk),
      .sys_rst(sys_rst), .link(sirp_if_i.device), .busy(busy), .paused(paused));
   sirp_master sirp_master_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .link(sirp_if_i.master), .start(start), .fast(fast), .pauseReq(pauseReq),
      .ready(ready), .ident(ident), .done(done));
   sirp_properties sirp_properties_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .selN(sirp_if_i.selN), .sclk(sirp_if_i.sclk), .sdi(sirp_if_i.sdi),
      .pauseN(sirp_if_i.pauseN), .sdo(sirp_if_i.sdo), .sdoEn(sirp_if_i.sdoEn));
   always #5 ref_clk = ~ref_clk;
   // wire monitor; edges during a pause are left out since they must not count
   always @(posedge ref_clk) begin
      sclkQ <= sirp_if_i.sclk;
      if (start) begin
         edgeCnt <= 0;
         wireBits <= 0;
      end else if (sirp_if_i.sclk && !sclkQ && !sirp_if_i.selN && sirp_if_i.pauseN) begin
         edgeCnt <= edgeCnt + 1;
         if (sirp_if_i.sdoEn) begin
            wireWord <= {wireWord[30:0], sirp_if_i.sdo};
            wireBits <= wireBits + 1;
         end
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // bounded wait for ready or the one-cycle done flag, sampled off the clock edge
   task automatic waitHigh(input bit useDone);
      int n;
      n = 0;
      while ((useDone ? done : ready) !== 1'b1) begin
         @(negedge ref_clk);
         n++;
         if (n > 4000) begin
            check("wait timeout", 0, 1);
            give_verdict();
         end
      end
   endtask
   // one read; optional pause of 300 cycles after pauseAt cycles
   task automatic doRead(input logic isFast, input int pauseAt);
      waitHigh(1'b0);
      @(posedge ref_clk) start <= 1'b1;
      fast <= isFast;
      @(posedge ref_clk) start <= 1'b0;
      if (pauseAt > 0) begin
         repeat (pauseAt) @(posedge ref_clk);
         pauseReq <= 1'b1;
         repeat (300) @(negedge ref_clk);
         check("paused", paused, 1);
         check("busy kept", busy, 1);
         check("sdo released", sirp_if_i.sdoEn, 0);
         check("select parked", sirp_if_i.selN, isFast);
         @(posedge ref_clk) pauseReq <= 1'b0;
      end
      waitHigh(1'b1);
      check("ident word", ident, EXP_WORD);
      check("maker", ident[`SIRP_MAKER_MSB:`SIRP_MAKER_LSB], {3'h5, 8'h3c});
      check("part", ident[`SIRP_PART_MSB:`SIRP_PART_LSB], 14'h1234);
      check("capacity", ident[`SIRP_CAP_MSB:`SIRP_CAP_LSB], 4'h9);
      check("revision", ident[`SIRP_REV_MSB:`SIRP_REV_LSB], 3'h6);
      check("link edges", edgeCnt, isFast ? 48 : 40);
      check("data bits", wireBits, 32);
      check("wire word", wireWord, EXP_WORD);
      check("pause cleared", paused, 0);
   endtask
   // main sequence: back to back plain, fast, then pauses in each phase
   initial begin
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 5; i++)
         doRead(i[0], pauseTab[i]);
      give_verdict();
   end
endmodule // tb_sirp
`default_nettype wire
